// ### hdl/cif_decoder.sv
// instruction format decoder with core flag register
`timescale 1ns/1ps
`default_nettype none
`include "cif_defs.svh"
module cif_decoder (
  input wire logic clk,
  input wire logic arst_n,
  output logic [15:0] pm_addr,
  output logic pm_rd,
  input wire logic [7:0] pm_rdata,
  input wire logic pm_ack,
  output logic dec_valid,
  input wire logic dec_ready,
  output logic [7:0] dec_opcode,
  output logic [7:0] dec_op1,
  output logic [7:0] dec_op2,
  output logic [1:0] dec_len,
  output var cif_pkg::cif_fmt_t dec_format,
  output logic [15:0] dec_target,
  output logic [15:0] dec_pc,
  output logic [8:0] dec_reg_addr,
  output logic [2:0] dec_page,
  input wire logic redirect_valid,
  input wire logic [15:0] redirect_pc,
  input wire logic alu_carry_we,
  input wire logic alu_carry,
  input wire logic alu_zero_we,
  input wire logic alu_zero,
  input wire logic irq,
  output logic int_take,
  output logic [7:0] flag_push_data,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rd_addr,
  output logic [7:0] reg_rdata,
  output logic reg_rd_hit,
  input wire logic [2:0] cur_pp,
  input wire logic [2:0] stk_pp,
  input wire logic [2:0] idx_pp,
  output logic [2:0] stack_page,
  output logic [7:0] flags
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ----------------------------------------
  // format decode
  // ----------------------------------------
  function automatic cif_pkg::cif_fmt_t fmt_of(input logic [7:0] op);
    fmt_of = cif_pkg::CIF_FMT_ONE;
    if (op[7])
      fmt_of = cif_pkg::CIF_FMT_REL12;
    else if (op == `CIF_OP_LONG_JUMP || op == `CIF_OP_LONG_CALL)
      fmt_of = cif_pkg::CIF_FMT_ABS16;
    else if (op == `CIF_OP_MOV_MM)
      fmt_of = cif_pkg::CIF_FMT_ADDR_ADDR;
    else if (op == `CIF_OP_AND_F || op == `CIF_OP_OR_F || op == `CIF_OP_XOR_F)
      fmt_of = cif_pkg::CIF_FMT_IMM8;
    else if (op == `CIF_OP_MVI_RD || op == `CIF_OP_MVI_WR || op == `CIF_OP_SWAP_XM)
      fmt_of = cif_pkg::CIF_FMT_ADDR8;
    else if (op < `CIF_OP_LOW_TOP)
    begin
      case (op[2:0])
        3'h0: fmt_of = cif_pkg::CIF_FMT_ONE;
        3'h1: fmt_of = cif_pkg::CIF_FMT_IMM8;
        3'h6, 3'h7: fmt_of = cif_pkg::CIF_FMT_ADDR_IMM;
        default: fmt_of = cif_pkg::CIF_FMT_ADDR8;
      endcase
    end
    else if ((op >= 8'h41 && op <= 8'h4A) || op == 8'h62 || op == 8'h63)
      fmt_of = cif_pkg::CIF_FMT_ADDR_IMM;
  endfunction

  function automatic logic [1:0] len_of(input cif_pkg::cif_fmt_t f);
    case (f)
      cif_pkg::CIF_FMT_ONE: len_of = 2'h1;
      cif_pkg::CIF_FMT_REL12, cif_pkg::CIF_FMT_IMM8, cif_pkg::CIF_FMT_ADDR8: len_of = 2'h2;
      default: len_of = 2'h3;
    endcase
  endfunction

  // ----------------------------------------
  // page selection
  // ----------------------------------------
  logic [7:0] next_op;
  logic [2:0] sel_page;
  logic [2:0] sel_stack;
  cif_page_sel u_page (
    .page_mode_field(flags[`CIF_BIT_PGM_HI:`CIF_BIT_PGM_LO]),
    .indexed(next_op < `CIF_OP_LOW_TOP && next_op[0] && next_op[2:0] != 3'h1),
    .cur_pp(cur_pp),
    .stk_pp(stk_pp),
    .idx_pp(idx_pp),
    .operand_page(sel_page),
    .stack_page(sel_stack)
  );

  // ----------------------------------------
  // fetch, issue and flags
  // ----------------------------------------
  cif_pkg::cif_state_t state, next_state;
  logic [15:0] pc, next_pc;
  logic [15:0] next_pm_addr, next_target;
  logic next_pm_rd, next_dec_valid, next_int_take, next_hit;
  logic [7:0] next_b1, next_b2, next_flags, next_push, next_rdata;
  logic [8:0] next_reg_addr;
  logic [2:0] next_page;
  logic accept;
  assign accept = state == cif_pkg::CIF_S_ISSUE && dec_ready;

  always_comb
  begin
    next_state = state;
    next_pc = pc;
    next_pm_addr = pm_addr;
    next_pm_rd = 1'b0;
    next_dec_valid = dec_valid;
    next_int_take = 1'b0;
    next_op = dec_opcode;
    next_b1 = dec_op1;
    next_b2 = dec_op2;
    next_target = dec_target;
    next_reg_addr = dec_reg_addr;
    next_page = dec_page;
    next_push = flag_push_data;
    next_flags = flags;
    if (alu_carry_we)
      next_flags[`CIF_BIT_CARRY] = alu_carry;
    if (alu_zero_we)
      next_flags[`CIF_BIT_ZERO] = alu_zero;
    case (state)
      cif_pkg::CIF_S_BOUND:
      begin
        if (redirect_valid)
          next_pc = redirect_pc;
        else if (flags[`CIF_BIT_GIE] && irq)
        begin
          next_int_take = 1'b1;
          next_push = flags;
          next_flags[`CIF_BIT_GIE] = 1'b0;
        end
        else
        begin
          next_pm_addr = pc;
          next_pm_rd = 1'b1;
          next_state = cif_pkg::CIF_S_B0;
        end
      end
      cif_pkg::CIF_S_B0:
        if (pm_ack)
        begin
          next_op = pm_rdata;
          next_b1 = 8'h00;
          next_b2 = 8'h00;
          if (len_of(fmt_of(pm_rdata)) == 2'h1)
            next_state = cif_pkg::CIF_S_ISSUE;
          else
          begin
            next_pm_addr = pc + 16'h0001;
            next_pm_rd = 1'b1;
            next_state = cif_pkg::CIF_S_B1;
          end
        end
      cif_pkg::CIF_S_B1:
        if (pm_ack)
        begin
          next_b1 = pm_rdata;
          if (len_of(fmt_of(dec_opcode)) == 2'h2)
            next_state = cif_pkg::CIF_S_ISSUE;
          else
          begin
            next_pm_addr = pc + 16'h0002;
            next_pm_rd = 1'b1;
            next_state = cif_pkg::CIF_S_B2;
          end
        end
      cif_pkg::CIF_S_B2:
        if (pm_ack)
        begin
          next_b2 = pm_rdata;
          next_state = cif_pkg::CIF_S_ISSUE;
        end
      cif_pkg::CIF_S_ISSUE:
        if (dec_ready)
        begin
          next_dec_valid = 1'b0;
          next_state = cif_pkg::CIF_S_BOUND;
          case (dec_opcode)
            `CIF_OP_AND_F: next_flags = flags & dec_op1 & `CIF_FLAGS_MASK;
            `CIF_OP_OR_F: next_flags = (flags | dec_op1) & `CIF_FLAGS_MASK;
            `CIF_OP_XOR_F: next_flags = (flags ^ dec_op1) & `CIF_FLAGS_MASK;
            default: ;
          endcase
          if (redirect_valid)
            next_pc = redirect_pc;
          else if (dec_format == cif_pkg::CIF_FMT_ABS16)
            next_pc = dec_target;
          else
            next_pc = pc + {14'h0000, dec_len};
        end
      default: next_state = cif_pkg::CIF_S_BOUND;
    endcase
    if (next_state == cif_pkg::CIF_S_ISSUE && state != cif_pkg::CIF_S_ISSUE)
    begin
      next_dec_valid = 1'b1;
      next_page = sel_page;
      next_reg_addr = {flags[`CIF_BIT_XIO], next_b1};
      if (fmt_of(next_op) == cif_pkg::CIF_FMT_REL12)
        next_target = pc + {{4{next_op[3]}}, next_op[3:0], next_b1};
      else if (fmt_of(next_op) == cif_pkg::CIF_FMT_ABS16)
        next_target = {next_b1, next_b2};
      else
        next_target = 16'h0000;
    end
    next_hit = reg_rd && reg_rd_addr == `CIF_ADDR_FLAGS;
    next_rdata = next_hit ? flags : 8'h00;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= cif_pkg::CIF_S_BOUND;
      pc <= 16'h0000;
      pm_addr <= 16'h0000;
      pm_rd <= 1'b0;
      dec_valid <= 1'b0;
      dec_opcode <= 8'h00;
      dec_op1 <= 8'h00;
      dec_op2 <= 8'h00;
      dec_len <= 2'h1;
      dec_format <= cif_pkg::CIF_FMT_ONE;
      dec_target <= 16'h0000;
      dec_pc <= 16'h0000;
      dec_reg_addr <= 9'h000;
      dec_page <= 3'h0;
      int_take <= 1'b0;
      flag_push_data <= 8'h00;
      reg_rdata <= 8'h00;
      reg_rd_hit <= 1'b0;
      stack_page <= 3'h0;
      flags <= `CIF_FLAGS_RESET;
    end
    else
    begin
      state <= next_state;
      pc <= next_pc;
      pm_addr <= next_pm_addr;
      pm_rd <= next_pm_rd;
      dec_valid <= next_dec_valid;
      dec_opcode <= next_op;
      dec_op1 <= next_b1;
      dec_op2 <= next_b2;
      dec_len <= len_of(fmt_of(next_op));
      dec_format <= fmt_of(next_op);
      dec_target <= next_target;
      dec_pc <= pc;
      dec_reg_addr <= next_reg_addr;
      dec_page <= next_page;
      int_take <= next_int_take;
      flag_push_data <= next_push;
      reg_rdata <= next_rdata;
      reg_rd_hit <= next_hit;
      stack_page <= sel_stack;
      flags <= next_flags;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_issue_long;
    accept && dec_format == cif_pkg::CIF_FMT_ABS16 && !redirect_valid;
  endsequence
  sequence s_quiet_bound;
    !redirect_valid && !(flags[`CIF_BIT_GIE] && irq);
  endsequence
  AST_SHORT_TARGET: assert property (
    $rose(dec_valid) && dec_format == cif_pkg::CIF_FMT_REL12
    |-> dec_target == dec_pc + {{4{dec_opcode[3]}}, dec_opcode[3:0], dec_op1})
    else $error("short target wrong");
  AST_LONG_JUMP: assert property (s_issue_long ##1 s_quiet_bound
    |=> pm_rd && pm_addr == $past(dec_target, 2))
    else $error("long jump not taken");
  AST_IMM_FORM: assert property (
    $rose(dec_valid) && dec_opcode < 8'h40 && dec_opcode[2:0] == 3'h1
    |-> dec_format == cif_pkg::CIF_FMT_IMM8 && dec_len == 2'h2)
    else $error("immediate form wrong");
  AST_MOVE_LEN: assert property ($rose(dec_valid) && dec_opcode == `CIF_OP_MOV_MM
    |-> dec_len == 2'h3 && dec_format == cif_pkg::CIF_FMT_ADDR_ADDR)
    else $error("memory move length wrong");
  AST_GIE_OFF: assert property (
    state == cif_pkg::CIF_S_BOUND && !flags[`CIF_BIT_GIE]
    |=> !int_take)
    else $error("interrupt taken while disabled");
  AST_INT_PUSH: assert property (
    state == cif_pkg::CIF_S_BOUND && !redirect_valid && flags[`CIF_BIT_GIE] && irq
    |=> int_take && flag_push_data == $past(flags) && !flags[`CIF_BIT_GIE])
    else $error("interrupt entry wrong");
  AST_FLAG_READ: assert property (reg_rd && reg_rd_addr == `CIF_ADDR_FLAGS
    |=> reg_rd_hit && reg_rdata == $past(flags))
    else $error("flag read wrong");
  AST_RESERVED: assert property ((flags & ~`CIF_FLAGS_MASK) == 8'h00)
    else $error("reserved flag bit set");
  AST_FLAG_HOLD: assert property (
    !accept && !alu_carry_we && !alu_zero_we && !next_int_take
    |=> $stable(flags))
    else $error("flags changed without cause");
  AST_REG_ADDR: assert property (
    $rose(dec_valid) |-> dec_reg_addr == {$past(flags[`CIF_BIT_XIO]), dec_op1})
    else $error("register bank bit wrong");
endmodule // cif_decoder
`default_nettype wire

// ### hdl/cif_defs.svh
// constants for the instruction format decoder and flag register
`ifndef CIF_DEFS_SVH
`define CIF_DEFS_SVH

// ----------------------------------------
// flag register
// ----------------------------------------
`define CIF_ADDR_FLAGS 8'hF7
`define CIF_FLAGS_RESET 8'h02
`define CIF_FLAGS_MASK 8'hD7
`define CIF_BIT_PGM_HI 7
`define CIF_BIT_PGM_LO 6
`define CIF_BIT_XIO 4
`define CIF_BIT_CARRY 2
`define CIF_BIT_ZERO 1
`define CIF_BIT_GIE 0

// ----------------------------------------
// opcodes with a format of their own, and the top of the low opcode block
// ----------------------------------------
`define CIF_OP_AND_F 8'h70
`define CIF_OP_OR_F 8'h71
`define CIF_OP_XOR_F 8'h72
`define CIF_OP_LONG_JUMP 8'h7D
`define CIF_OP_LONG_CALL 8'h7C
`define CIF_OP_MOV_MM 8'h5F
`define CIF_OP_MVI_RD 8'h3E
`define CIF_OP_MVI_WR 8'h3F
`define CIF_OP_SWAP_XM 8'h4D
`define CIF_OP_LOW_TOP 8'h40

`endif

// ### hdl/cif_page_sel.sv
// page selection for operand and stack accesses
`timescale 1ns/1ps
`default_nettype none
module cif_page_sel (
  input wire logic [1:0] page_mode_field,
  input wire logic indexed,
  input wire logic [2:0] cur_pp,
  input wire logic [2:0] stk_pp,
  input wire logic [2:0] idx_pp,
  output logic [2:0] operand_page,
  output logic [2:0] stack_page
);
  always_comb
  begin
    // mode 0 keeps every operand in page 0
    operand_page = 3'h0;
    if (page_mode_field == 2'h3 && indexed)
      operand_page = idx_pp;
    else if (page_mode_field[1])
      operand_page = cur_pp;
    stack_page = (page_mode_field == 2'h1) ? idx_pp : stk_pp;
  end
endmodule // cif_page_sel
`default_nettype wire

// ### hdl/cif_pkg.sv
// types shared by the decoder files
package cif_pkg;
  typedef enum logic [2:0] {
    CIF_FMT_ONE, CIF_FMT_REL12, CIF_FMT_IMM8, CIF_FMT_ADDR8,
    CIF_FMT_ABS16, CIF_FMT_ADDR_IMM, CIF_FMT_ADDR_ADDR
  } cif_fmt_t;
  typedef enum logic [2:0] {
    CIF_S_BOUND, CIF_S_B0, CIF_S_B1, CIF_S_B2, CIF_S_ISSUE
  } cif_state_t;
endpackage

// ### tb/cif_decoder_tb_top.sv
// self-checking bench for the instruction format decoder
`timescale 1ns/1ps
`default_nettype none
module cif_decoder_tb_top;
  logic clk = 1'b0, arst_n = 1'b0, dec_ready = 1'b0, slow = 1'b0, irq = 1'b0, reg_rd = 1'b0;
  logic alu_carry_we = 1'b0, alu_carry = 1'b0, alu_zero_we = 1'b0, alu_zero = 1'b0;
  logic redirect_valid = 1'b0;
  logic [15:0] redirect_pc = 16'h0000;
  logic [2:0] cur_pp = 3'h1, stk_pp = 3'h2, idx_pp = 3'h5;
  logic [7:0] reg_rd_addr = 8'h00;
  logic pm_rd, pm_ack, dec_valid, int_take, reg_rd_hit;
  logic [7:0] pm_rdata, dec_opcode, dec_op1, dec_op2, flag_push_data, reg_rdata, flags, efl;
  logic [15:0] pm_addr, dec_target, dec_pc;
  logic [1:0] dec_len;
  cif_pkg::cif_fmt_t dec_format;
  logic [8:0] dec_reg_addr;
  logic [2:0] dec_page, stack_page;
  int mismatches = 0;
  int total_checks = 0;
  int takes = 0;
  // pc, opcode, op1, op2, length, format, target
  logic [63:0] tbl [16] = '{64'h0000_71D500_2_2_0000, 64'h0002_72C400_2_2_0000,
    64'h0004_8FFE00_2_1_0002, 64'h0006_880000_2_1_F806, 64'h0008_87FF00_2_1_0807,
    64'h000A_7D1234_3_4_1234, 64'h1234_5F0705_3_6_0000, 64'h1237_412055_3_5_0000,
    64'h123A_2A1000_2_3_0000, 64'h123C_400000_1_0_0000, 64'h123D_71C000_2_2_0000,
    64'h123F_2B0900_2_3_0000, 64'h1241_2A0900_2_3_0000, 64'h1243_705300_2_2_0000,
    64'h1245_294400_2_2_0000, 64'h1247_7C1234_3_4_1234};

  cif_decoder dut (.clk, .arst_n, .pm_addr, .pm_rd, .pm_rdata, .pm_ack, .dec_valid, .dec_ready,
    .dec_opcode, .dec_op1, .dec_op2, .dec_len, .dec_format, .dec_target, .dec_pc, .dec_reg_addr,
    .dec_page, .redirect_valid, .redirect_pc, .alu_carry_we, .alu_carry, .alu_zero_we,
    .alu_zero, .irq, .int_take, .flag_push_data, .reg_rd, .reg_rd_addr, .reg_rdata,
    .reg_rd_hit, .cur_pp, .stk_pp, .idx_pp, .stack_page, .flags);
  cif_prog_mem mem_model (.clk, .pm_rd, .pm_addr, .slow, .pm_rdata, .pm_ack);

  always #50 clk = ~clk;
  always @(posedge clk)
    if (int_take === 1'b1)
      takes++;

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      mismatches++;
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // wait for one decoded instruction, compare, accept
  // ----------------------------------------
  task automatic take(input int i);
    logic [63:0] e;
    logic [15:0] pg;
    int n;
    e = tbl[i];
    pg = (efl[7:6] == 2'b00) ? 16'h0000 : (e[40] ? 16'h0005 : 16'h0001);
    n = 0;
    while (dec_valid !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check("dec_valid", {15'h0, dec_valid}, 16'h0001);
    check("dec_pc", dec_pc, e[63:48]);
    check("dec_opcode", {8'h00, dec_opcode}, {8'h00, e[47:40]});
    check("dec_op1", {8'h00, dec_op1}, {8'h00, e[39:32]});
    check("dec_op2", {8'h00, dec_op2}, {8'h00, e[31:24]});
    check("dec_len", {14'h0, dec_len}, {12'h0, e[23:20]});
    check("dec_format", {13'h0, dec_format}, {12'h0, e[19:16]});
    check("dec_target", dec_target, e[15:0]);
    check("dec_reg_addr", {7'h00, dec_reg_addr}, {7'h00, efl[4], e[39:32]});
    check("stack_page", {13'h0, stack_page}, (efl[7:6] == 2'b01) ? 16'h5 : 16'h2);
    if (e[19:16] == 4'h3 && (efl[7:6] == 2'b00 || efl[7:6] == 2'b11))
      check("dec_page", {13'h0, dec_page}, pg);
    dec_ready = 1'b1;
    @(negedge clk);
    dec_ready = 1'b0;
    case (e[47:40])
      8'h70: efl = efl & e[39:32] & 8'hD7;
      8'h71: efl = (efl | e[39:32]) & 8'hD7;
      8'h72: efl = (efl ^ e[39:32]) & 8'hD7;
      default: efl = efl;
    endcase
    check("flags", {8'h00, flags}, {8'h00, efl});
  endtask

  // leaves the read strobe up; every call raises it again and the caller lowers it after the last read
  task automatic rreg(input logic [7:0] a, input logic hit, input logic [7:0] d);
    reg_rd = 1'b1;
    reg_rd_addr = a;
    @(negedge clk);
    check("reg_rd_hit", {15'h0, reg_rd_hit}, {15'h0, hit});
    check("reg_rdata", {8'h00, reg_rdata}, {8'h00, d});
  endtask

  initial
  begin
    #2_000_000;
    mismatches++;
    results;
  end

  initial
  begin
    efl = 8'h02;
    repeat (3) @(negedge clk);
    check("flags", {8'h00, flags}, 16'h0002);
    check("dec_len", {14'h0, dec_len}, 16'h0001);
    arst_n = 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      slow = (i >= 6);
      take(i);
    end
    $display("test formats done");
    // the request meets the boundary before the next fetch, so entry comes first
    irq = 1'b1;
    @(negedge clk);
    check("int_take", {15'h0, int_take}, 16'h0001);
    @(negedge clk);
    check("int_take", takes[15:0], 16'h0001);
    check("flag_push_data", {8'h00, flag_push_data}, {8'h00, efl});
    efl = efl & 8'hFE;
    check("flags", {8'h00, flags}, {8'h00, efl});
    for (int i = 9; i < 16; i++)
      take(i);
    check("int_take", takes[15:0], 16'h0001);
    $display("test interrupt done");
    rreg(8'hF7, 1'b1, efl);
    rreg(8'hF6, 1'b0, 8'h00);
    reg_rd = 1'b0;
    alu_carry_we = 1'b1;
    alu_carry = 1'b1;
    @(negedge clk);
    alu_carry_we = 1'b0;
    efl = efl | 8'h04;
    check("flags", {8'h00, flags}, {8'h00, efl});
    alu_zero_we = 1'b1;
    @(negedge clk);
    alu_zero_we = 1'b0;
    efl = efl & 8'hFD;
    check("flags", {8'h00, flags}, {8'h00, efl});
    $display("test registers done");
    results;
  end
endmodule // cif_decoder_tb_top
`default_nettype wire

// ### tb/cif_prog_mem.sv
// program memory model answering byte fetches of the decoder
`timescale 1ns/1ps
`default_nettype none
module cif_prog_mem (
  input wire logic clk,
  input wire logic pm_rd,
  input wire logic [15:0] pm_addr,
  input wire logic slow,
  output logic [7:0] pm_rdata,
  output logic pm_ack
);
  logic [7:0] mem [0:255];
  logic [7:0] last;
  logic [15:0] addr_q;
  logic busy;
  int wait_cnt;
  // ----------------------------------------
  // program image: flag writes keep reserved bits zero
  // ----------------------------------------
  logic [103:0] lo = 104'h71D572C48FFE880087FF7D1234;
  logic [175:0] hi = 176'h5F0705412055_2A10_40_71C0_2B09_2A09_7053_2944_7C1234;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h40;
    for (int i = 0; i < 13; i++) mem[i] = lo[8*(12-i) +: 8];
    for (int i = 0; i < 22; i++) mem[8'h34 + i] = hi[8*(21-i) +: 8];
    pm_ack = 1'b0;
    pm_rdata = 8'h00;
    last = 8'h00;
    busy = 1'b0;
    wait_cnt = 0;
  end
  // ----------------------------------------
  // one outstanding read, prompt or slow answer
  // ----------------------------------------
  always @(posedge clk)
  begin
    pm_ack <= 1'b0;
    pm_rdata <= ~last;
    if (pm_rd === 1'b1)
    begin
      busy <= 1'b1;
      addr_q <= pm_addr;
      wait_cnt <= slow ? 3 : 0;
    end
    else if (busy)
    begin
      if (wait_cnt == 0)
      begin
        pm_ack <= 1'b1;
        pm_rdata <= mem[addr_q[7:0]];
        last <= mem[addr_q[7:0]];
        busy <= 1'b0;
      end
      else
        wait_cnt <= wait_cnt - 1;
    end
  end
endmodule // cif_prog_mem
`default_nettype wire
